// ==== vcp_pkg.sv ====
/*
  Shared constants and types for the video capture port and its pixel parser,
  followed by the pixel parser itself.
  Assumes a single 100 MHz MCLK domain and APB register access.
*/
// Notes on behaviour
// [R1] Re-enabling the port with the processing path selected stalls the descriptor list.
// [R2] The stall occurs in both sync modes; discrete sync stalls on its first run.
// [R3] Recovery: disable, reset port and FIFO, post abort list, wait, release resets.
// [R4] Discrete start list begins with a discarding, non-emitting direct data descriptor.
// [R5] Then a sync descriptor on the same channel, waiting for end of frame.
// [R6] Then a configuration descriptor selecting the processing path, then data descriptors.
// [R7] Before posting, software selects the direct path and enables the port.
// [R8] The list holds at sync until end of frame; config applies during blanking.
// [R9] In discrete sync the active-video strobe marks the active region written.
// [R10] The decoder holds the active-video strobe on every line, blanking included; the model drops it in horizontal blanking of active lines.
// [R11] Vertical blanking lines are never written to memory.
// [R12] Release resets only after the abort list completes; re-enable after release.
`timescale 1ns/100ps
`default_nettype none

package vcp_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [11:0] CTRL_OFS   = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] POST_OFS   = 12'h008;
  localparam logic [11:0] FRAMES_OFS = 12'h00C;
  localparam logic [11:0] DESC_OFS   = 12'h040;
  localparam int          CTRL_EN    = 0;
  localparam int          CTRL_DISC  = 1;
  localparam int          CTRL_MUX   = 2;
  localparam int          CTRL_PRST  = 3;
  localparam int          CTRL_FRST  = 4;
  localparam int          STAT_DONE  = 1;
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  // ----------------------------------------------------------------------
  // Descriptor word layout
  // ----------------------------------------------------------------------
  localparam int          LIST_DEPTH = 8;
  localparam int          TYPE_HI    = 31;
  localparam int          TYPE_LO    = 28;
  localparam int          CHAN_HI    = 27;
  localparam int          CHAN_LO    = 24;
  localparam int          MUXV_BIT   = 2;
  localparam int          DISCARD    = 1;
  localparam int          EMIT       = 0;
  typedef enum logic [3:0] {
    DESC_DATA   = 4'b0001,
    DESC_SYNC   = 4'b0010,
    DESC_CONFIG = 4'b0011,
    DESC_ABORT  = 4'b0100
  } desc_type_t;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,
    ST_DATA  = 3'b010,
    ST_SYNC  = 3'b011,
    ST_CFG   = 3'b100,
    ST_ABORT = 3'b101
  } list_state_t;
  // ----------------------------------------------------------------------
  // Embedded sync code
  // ----------------------------------------------------------------------
  localparam logic [7:0]  CODE_FF    = 8'hFF;
  localparam logic [7:0]  CODE_00    = 8'h00;
  localparam int          XY_H       = 4;
  localparam int          XY_V       = 5;
endpackage

// Decodes frames and active pixels from the decoder pins
module pixel_parser
  import vcp_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clear,
  // Mode
  input  wire logic        discrete,
  // Decoder pins
  input  wire logic [23:0] pin_data,
  input  wire logic        pin_vsync,
  input  wire logic        pin_act,
  // Parsed stream
  output logic             pix_valid,
  output logic [23:0]      pix_data,
  output logic             sof,
  output logic             eof
);
  logic [23:0] d_s1, d_s2;
  logic        vs_s1, vs_s2, act_s1, act_s2;
  logic [1:0]  hdr, next_hdr;
  logic        line_act, next_line_act, vb, next_vb;
  logic        next_valid, next_sof, next_eof;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      d_s1   <= 24'h00_0000;
      d_s2   <= 24'h00_0000;
      vs_s1  <= 1'b0;
      vs_s2  <= 1'b0;
      act_s1 <= 1'b0;
      act_s2 <= 1'b0;
    end else begin
      d_s1   <= pin_data;
      d_s2   <= d_s1;
      vs_s1  <= pin_vsync;
      vs_s2  <= vs_s1;
      act_s1 <= pin_act;
      act_s2 <= act_s1;
    end
  end

  always_comb begin
    next_hdr      = 2'd0;
    next_line_act = line_act;
    next_vb       = vb;
    next_sof      = 1'b0;
    next_eof      = 1'b0;
    next_valid    = 1'b0;
    if (discrete) begin
      // Vsync high is vertical blanking even while the strobe stays up
      next_vb    = vs_s2;
      next_valid = act_s2 && !vs_s2;                  // [R9] [R11]
      next_eof   = vs_s2 && !vb;
      next_sof   = !vs_s2 && vb;
    end else begin
      case (hdr)
        2'd0: next_hdr = (d_s2[7:0] == CODE_FF) ? 2'd1 : 2'd0;
        2'd1: next_hdr = (d_s2[7:0] == CODE_00) ? 2'd2 : 2'd0;
        2'd2: next_hdr = (d_s2[7:0] == CODE_00) ? 2'd3 : 2'd0;
        default: begin
          next_hdr      = 2'd0;
          next_vb       = d_s2[XY_V];
          next_line_act = !d_s2[XY_H] && !d_s2[XY_V];  // [R11]
          next_eof      = d_s2[XY_V] && !vb;
          next_sof      = !d_s2[XY_V] && vb;
        end
      endcase
      next_valid = line_act && (hdr == 2'd0) && (d_s2[7:0] != CODE_FF);
    end
    if (clear) begin
      next_hdr      = 2'd0;
      next_line_act = 1'b0;
      next_vb       = 1'b1;
      next_valid    = 1'b0;
      next_sof      = 1'b0;
      next_eof      = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hdr       <= 2'd0;
      line_act  <= 1'b0;
      vb        <= 1'b1;
      pix_valid <= 1'b0;
      pix_data  <= 24'h00_0000;
      sof       <= 1'b0;
      eof       <= 1'b0;
    end else begin
      hdr       <= next_hdr;
      line_act  <= next_line_act;
      vb        <= next_vb;
      pix_valid <= next_valid;
      pix_data  <= d_s2;
      sof       <= next_sof;
      eof       <= next_eof;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  blank_not_written_a: assert property (discrete && vs_s2 && !clear |=> !pix_valid) // [R11]
    else $error("pixel passed during vertical blanking");
  strobe_gates_a: assert property (discrete && !clear && act_s2 && !vs_s2 |=> pix_valid) // [R9]
    else $error("active pixel not passed");
endmodule // pixel_parser

`default_nettype wire

// ==== video_capture_port.sv ====
/*
  Video capture port: APB registers, pixel parser, direct or processing path
  mux and a descriptor list engine that writes frames to the DMA side.
  Assumes pins from an external decoder and a DMA sink that never stalls.
*/
`timescale 1ns/100ps
`default_nettype none
module video_capture_port
  import vcp_pkg::*;
(
  // Clock and reset
  input  wire logic        MCLK,
  input  wire logic        RST_N,
  // APB slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Decoder pins
  input  wire logic [23:0] PIX_DATA,
  input  wire logic        VSYNC,
  input  wire logic        ACTIVE_VIDEO_STROBE,
  // DMA side
  output logic             DMA_WR_VALID,
  output logic [23:0]      DMA_WR_DATA,
  output logic [3:0]       DMA_WR_CHAN,
  output logic             DESC_OUT_VALID,
  output logic [3:0]       DESC_OUT_CHAN
);
  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [31:0] desc_mem [LIST_DEPTH];
  list_state_t state, next_state;
  logic [2:0]  idx, next_idx;
  logic [3:0]  len, next_len;
  logic [31:0] cur, next_cur;
  logic        enable, next_enable, discrete, next_discrete;
  logic        mux_proc, next_mux_proc, prst, next_prst, frst, next_frst;
  logic        hung, next_hung, ran_before, next_ran_before;
  logic        busy, next_busy, done, next_done;
  logic        in_frame, next_in_frame, open, next_open;
  logic [15:0] frames, next_frames;
  logic        proc_valid;
  logic [23:0] proc_data;
  logic        next_wr_valid, next_desc_valid;
  logic [31:0] next_prdata, rd_word;
  logic        next_pready, next_pslverr, mapped;
  logic        pix_valid, sof, eof, src_valid, advance, last;
  logic [23:0] pix_data, src_data;
  logic        acc, wr_fire, desc_hit;

  pixel_parser u_parser (
    .clk       (MCLK),
    .rst_n     (RST_N),
    .clear     (prst || frst || !enable),
    .discrete  (discrete),
    .pin_data  (PIX_DATA),
    .pin_vsync (VSYNC),
    .pin_act   (ACTIVE_VIDEO_STROBE),
    .pix_valid (pix_valid),
    .pix_data  (pix_data),
    .sof       (sof),
    .eof       (eof)
  );

  // ----------------------------------------------------------------------
  // APB decode and read mux
  // ----------------------------------------------------------------------
  assign acc      = PSEL && PENABLE;
  assign wr_fire  = acc && PREADY && PWRITE;
  assign desc_hit = (PADDR[11:5] == DESC_OFS[11:5]) && (PADDR[1:0] == 2'b00);
  assign last     = ({1'b0, idx} + 4'd1) == len;

  always_comb begin
    mapped  = 1'b1;
    rd_word = RESET_WORD;
    if (desc_hit) begin
      rd_word = desc_mem[PADDR[4:2]];
    end else begin
      case (PADDR)
        CTRL_OFS:   rd_word = {27'd0, frst, prst, mux_proc, discrete, enable};
        STATUS_OFS: rd_word = {21'd0, idx, 4'd0, in_frame, hung, done, busy};
        POST_OFS:   rd_word = {28'd0, len};
        FRAMES_OFS: rd_word = {16'd0, frames};
        default:    mapped  = 1'b0;
      endcase
    end
    next_pready  = acc && !PREADY;
    next_prdata  = (acc && !PREADY && !PWRITE) ? rd_word : RESET_WORD;
    next_pslverr = acc && !PREADY && !mapped;
  end

  // Descriptor slots are written only by software
  always_ff @(posedge MCLK) begin
    if (wr_fire && desc_hit) begin
      desc_mem[PADDR[4:2]] <= PWDATA;
    end
  end

  // ----------------------------------------------------------------------
  // Control, path mux and descriptor engine
  // ----------------------------------------------------------------------
  // The processing path is modelled as one register stage of latency
  assign src_valid = mux_proc ? proc_valid : pix_valid;
  assign src_data  = mux_proc ? proc_data : pix_data;

  always_comb begin
    next_enable     = enable;
    next_discrete   = discrete;
    next_mux_proc   = mux_proc;
    next_prst       = prst;
    next_frst       = frst;
    next_len        = len;
    next_state      = state;
    next_idx        = idx;
    next_cur        = cur;
    next_busy       = busy;
    next_done       = done;
    next_open       = open;
    next_frames     = frames;
    next_hung       = hung;
    next_ran_before = ran_before;
    next_in_frame   = in_frame;
    next_wr_valid   = 1'b0;
    next_desc_valid = 1'b0;
    advance         = 1'b0;
    if (wr_fire && PADDR == CTRL_OFS) begin
      next_enable   = PWDATA[CTRL_EN];
      next_discrete = PWDATA[CTRL_DISC];
      next_mux_proc = PWDATA[CTRL_MUX];                // [R7]
      next_prst     = PWDATA[CTRL_PRST];
      next_frst     = PWDATA[CTRL_FRST];
    end
    if (wr_fire && PADDR == STATUS_OFS && PWDATA[STAT_DONE]) begin
      next_done = 1'b0;
    end
    if (sof) begin
      next_in_frame = 1'b1;
    end else if (eof) begin
      next_in_frame = 1'b0;
    end
    // Restart with processing in the path locks the list up
    // The values being written count, so enable and mux in one write also lock up
    if (!enable && next_enable && next_mux_proc && (next_discrete || ran_before)) begin
      next_hung = 1'b1;                                // [R1] [R2]
    end
    if (enable && !next_enable) begin
      next_ran_before = 1'b1;
    end
    if (prst) begin
      next_hung       = 1'b0;                          // [R3]
      next_ran_before = 1'b0;
      next_in_frame   = 1'b0;
    end
    case (state)
      ST_IDLE: begin
        if (wr_fire && PADDR == POST_OFS && PWDATA[3:0] != 4'd0) begin
          next_len   = PWDATA[3:0];
          next_idx   = 3'd0;
          next_busy  = 1'b1;
          next_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        next_cur  = desc_mem[idx];
        next_open = 1'b0;
        case (desc_mem[idx][TYPE_HI:TYPE_LO])
          DESC_DATA:   next_state = ST_DATA;
          DESC_SYNC:   next_state = ST_SYNC;
          DESC_CONFIG: next_state = ST_CFG;
          DESC_ABORT:  next_state = ST_ABORT;
          default:     advance    = 1'b1;
        endcase
      end
      ST_DATA: begin
        // A locked-up port never finishes a frame
        if (sof && !hung) begin
          next_open = 1'b1;                            // [R1]
        end
        // In discrete sync on the direct path the first pixel of a frame arrives together with its start pulse
        if ((open || sof) && src_valid && !hung && !cur[DISCARD]) begin
          next_wr_valid = 1'b1;                        // [R4]
        end
        if (open && eof && !hung) begin
          next_desc_valid = cur[EMIT];                 // [R4]
          next_frames     = frames + 16'h0001;
          advance         = 1'b1;
        end
      end
      ST_SYNC: begin
        advance = eof;                                 // [R5] [R8]
      end
      ST_CFG: begin
        if (!in_frame) begin
          next_mux_proc = cur[MUXV_BIT];               // [R6] [R8]
          advance       = 1'b1;
        end
      end
      ST_ABORT: begin
        advance = 1'b1;                                // [R3]
      end
      default: next_state = ST_IDLE;
    endcase
    if (advance) begin
      next_open = 1'b0;
      if (last) begin
        next_state = ST_IDLE;
        next_busy  = 1'b0;
        next_done  = 1'b1;                             // [R12]
      end else begin
        next_idx   = idx + 3'd1;
        next_state = ST_FETCH;
      end
    end
    // A port reset drops a list waiting on the port, so an abort list can be posted
    if (prst && (state == ST_DATA || state == ST_SYNC)) begin
      next_state = ST_IDLE;                            // [R3]
      next_busy  = 1'b0;
      next_open  = 1'b0;
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      enable         <= 1'b0;
      discrete       <= 1'b0;
      mux_proc       <= 1'b0;
      prst           <= 1'b0;
      frst           <= 1'b0;
      len            <= 4'd0;
      state          <= ST_IDLE;
      idx            <= 3'd0;
      cur            <= RESET_WORD;
      busy           <= 1'b0;
      done           <= 1'b0;
      open           <= 1'b0;
      frames         <= 16'h0000;
      hung           <= 1'b0;
      ran_before     <= 1'b0;
      in_frame       <= 1'b0;
      proc_valid     <= 1'b0;
      proc_data      <= 24'h00_0000;
      DMA_WR_VALID   <= 1'b0;
      DMA_WR_DATA    <= 24'h00_0000;
      DMA_WR_CHAN    <= 4'h0;
      DESC_OUT_VALID <= 1'b0;
      DESC_OUT_CHAN  <= 4'h0;
      PRDATA         <= RESET_WORD;
      PREADY         <= 1'b0;
      PSLVERR        <= 1'b0;
    end else begin
      enable         <= next_enable;
      discrete       <= next_discrete;
      mux_proc       <= next_mux_proc;
      prst           <= next_prst;
      frst           <= next_frst;
      len            <= next_len;
      state          <= next_state;
      idx            <= next_idx;
      cur            <= next_cur;
      busy           <= next_busy;
      done           <= next_done;
      open           <= next_open;
      frames         <= next_frames;
      hung           <= next_hung;
      ran_before     <= next_ran_before;
      in_frame       <= next_in_frame;
      proc_valid     <= pix_valid;
      proc_data      <= pix_data;
      DMA_WR_VALID   <= next_wr_valid;
      DMA_WR_DATA    <= src_data;
      DMA_WR_CHAN    <= cur[CHAN_HI:CHAN_LO];
      DESC_OUT_VALID <= next_desc_valid;
      DESC_OUT_CHAN  <= cur[CHAN_HI:CHAN_LO];
      PRDATA         <= next_prdata;
      PREADY         <= next_pready;
      PSLVERR        <= next_pslverr;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_N);
  sequence restart_proc_s;
    $rose(enable) ##0 mux_proc && $past(ran_before) && !$past(prst);
  endsequence
  sequence first_disc_s;
    $rose(enable) ##0 mux_proc && discrete && !$past(prst);
  endsequence
  restart_hang_a: assert property (restart_proc_s |-> hung) // [R1]
    else $error("restart with processing path did not lock up");
  discrete_hang_a: assert property (first_disc_s |-> hung) // [R2]
    else $error("discrete first run with processing path did not lock up");
  hung_no_write_a: assert property (hung && $past(hung) |-> !DMA_WR_VALID) // [R1]
    else $error("locked-up port wrote pixels");
  sync_holds_a: assert property (state == ST_SYNC && !eof && !prst |=> state == ST_SYNC) // [R8]
    else $error("sync descriptor left before end of frame");
  cfg_blank_a: assert property (state == ST_CFG && !in_frame |=> mux_proc == cur[MUXV_BIT]) // [R8]
    else $error("configuration not applied in blanking");
  cfg_waits_a: assert property (state == ST_CFG && in_frame |=> state == ST_CFG) // [R8]
    else $error("configuration applied during active frame");
  discard_a: assert property (state == ST_DATA && cur[DISCARD] |=> !DMA_WR_VALID) // [R4]
    else $error("discarding descriptor wrote data");
  abort_done_a: assert property (state == ST_ABORT |=> state != ST_ABORT) // [R3]
    else $error("abort descriptor did not complete");
  reset_clears_a: assert property (prst |=> !hung [*2]) // [R3]
    else $error("port reset did not clear lock-up");
endmodule // video_capture_port

`default_nettype wire

// ==== video_decoder_model.sv ====
/*
  Behavioural discrete-sync video decoder that drives the capture port pins.
  Assumes the bench raises go for one frame and waits for busy to fall.
*/
`timescale 1ns/100ps
`default_nettype none
module video_decoder_model #(
  parameter int VB_LINES  = 2,
  parameter int ACT_LINES = 3,
  parameter int PIXELS    = 4,
  parameter int HBLANK    = 2
) (
  // Clock and control
  input  wire logic   clk,
  input  wire logic   go,
  output logic        busy,
  // Decoder pins
  output logic [23:0] pix_data,
  output logic        vsync,
  output logic        act
);
  // ----------------------------------------------------------------------
  // Frame generator
  // ----------------------------------------------------------------------
  logic [6:0] frame_no;
  logic       live;

  // Bit 23 marks a blanking sample, so any write of one is easy to spot
  initial begin
    busy     = 1'b0;
    vsync    = 1'b1;
    act      = 1'b1;
    pix_data = 24'hAA_AAAA;
    frame_no = 7'h00;
    live     = 1'b0;
    forever begin
      @(posedge clk);
      if (go) begin
        busy <= 1'b1;
        for (int l = 0; l < VB_LINES + ACT_LINES; l++) begin
          for (int p = 0; p < PIXELS + HBLANK; p++) begin
            live = (l >= VB_LINES) && (p < PIXELS);
            vsync    <= (l < VB_LINES);
            act      <= (l < VB_LINES) || live;
            pix_data <= live ? {1'b0, frame_no, l[7:0], p[7:0]} : {1'b1, ~pix_data[22:0]};
            @(posedge clk);
          end
        end
        vsync    <= 1'b1;
        act      <= 1'b1;
        busy     <= 1'b0;
        frame_no <= frame_no + 7'h01;
      end else begin
        // Idle samples keep changing so a stale value never looks valid
        pix_data <= {1'b1, ~pix_data[22:0]};
      end
    end
  end
endmodule // video_decoder_model
`default_nettype wire

// ==== tb_top.sv ====
/*
  Self-checking bench for the video capture port: APB register tasks,
  discrete-sync start list, lock-up and reset recovery.
  Assumes the decoder model of video_decoder_model.sv on the pixel pins.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import vcp_pkg::*;
;
  // ----------------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------------
  localparam int FRAME_PIX = 12;
  logic        mclk    = 1'b0;
  logic        rst_n   = 1'b0;
  logic        psel    = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite  = 1'b0;
  logic [11:0] paddr   = 12'h000;
  logic [31:0] pwdata  = 32'h0000_0000;
  logic        go      = 1'b0;
  logic [31:0] prdata, rq;
  logic        pready, pslverr, re, busy, vsync, act;
  logic        dma_valid, desc_valid;
  logic [23:0] pix, dma_data;
  logic [3:0]  dma_chan, desc_chan;
  int          error_cnt, checks_done, cyc, blank_wr, desc_cnt;
  int          wr_cnt[16];

  always #5 mclk = ~mclk;

  video_capture_port DUT (.MCLK(mclk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .PIX_DATA(pix), .VSYNC(vsync), .ACTIVE_VIDEO_STROBE(act),
    .DMA_WR_VALID(dma_valid), .DMA_WR_DATA(dma_data), .DMA_WR_CHAN(dma_chan),
    .DESC_OUT_VALID(desc_valid), .DESC_OUT_CHAN(desc_chan));

  video_decoder_model #(.ACT_LINES(3), .PIXELS(4)) decoder (.clk(mclk), .go(go),
    .busy(busy), .pix_data(pix), .vsync(vsync), .act(act));

  // ----------------------------------------------------------------------
  // Monitors and helpers
  // ----------------------------------------------------------------------
  // Sampled mid-cycle: registered outputs are settled there
  always @(negedge mclk) begin
    if (dma_valid === 1'b1) begin
      wr_cnt[dma_chan]++;
      if (dma_data[23] !== 1'b0) blank_wr++;
    end
    if (desc_valid === 1'b1) begin
      desc_cnt++;
      wr_cnt[15] = 32'(desc_chan);
    end
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("checks=%0d errors=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Read right after the edge, these are the values that edge sampled
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(rq & m, e);
  endtask

  task automatic wait_done();
    do begin
      apb(1'b0, STATUS_OFS, 32'h0000_0000);
    end while (rq[STAT_DONE] !== 1'b1);
  endtask

  task automatic send_frame();
    @(posedge mclk);
    go <= 1'b1;
    @(posedge mclk);
    go <= 1'b0;
    do begin
      @(negedge mclk);
    end while (busy !== 1'b0);
    repeat (8) @(posedge mclk);
  endtask

  function automatic logic [31:0] desc(input desc_type_t t, input logic [3:0] ch,
                                       input logic [2:0] f);
    desc = {t, ch, 21'h0_0000, f};
  endfunction

  // ----------------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (6) @(posedge mclk);
    rst_n <= 1'b1;
    rd_chk(CTRL_OFS, 32'hFFFF_FFFF, RESET_WORD);
    rd_chk(STATUS_OFS, 32'hFFFF_FFFF, RESET_WORD);
    rd_chk(FRAMES_OFS, 32'hFFFF_FFFF, RESET_WORD);
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk(rq, 32'h0000_0000);
    chk(32'(re), 32'h0000_0001);
    // Discrete start list: discard, sync on EOF, config, real data
    apb(1'b1, DESC_OFS, desc(DESC_DATA, 4'h2, 3'b010));
    apb(1'b1, DESC_OFS + 12'h004, desc(DESC_SYNC, 4'h2, 3'b000));
    apb(1'b1, DESC_OFS + 12'h008, desc(DESC_CONFIG, 4'h2, 3'b100));
    apb(1'b1, DESC_OFS + 12'h00C, desc(DESC_DATA, 4'h3, 3'b001));
    apb(1'b1, CTRL_OFS, 32'h0000_0003);
    apb(1'b1, POST_OFS, 32'h0000_0004);
    rd_chk(STATUS_OFS, 32'h0000_0007, 32'h0000_0001);
    repeat (4) send_frame();
    chk(32'(wr_cnt[2]), 32'h0000_0000);
    chk(32'(wr_cnt[3]), 32'(FRAME_PIX));
    chk(32'(blank_wr), 32'h0000_0000);
    chk(32'(desc_cnt), 32'h0000_0001);
    chk(32'(wr_cnt[15]), 32'h0000_0003);
    rd_chk(STATUS_OFS, 32'h0000_0007, 32'h0000_0002);
    rd_chk(FRAMES_OFS, 32'h0000_FFFF, 32'h0000_0002);
    // Enabling straight into the processing path in discrete mode hangs
    apb(1'b1, STATUS_OFS, 32'h0000_0002);
    apb(1'b1, CTRL_OFS, 32'h0000_000E);
    apb(1'b1, CTRL_OFS, 32'h0000_0006);
    apb(1'b1, CTRL_OFS, 32'h0000_0007);
    apb(1'b1, DESC_OFS, desc(DESC_DATA, 4'h5, 3'b001));
    apb(1'b1, POST_OFS, 32'h0000_0001);
    send_frame();
    chk(32'(wr_cnt[5]), 32'h0000_0000);
    rd_chk(STATUS_OFS, 32'h0000_0007, 32'h0000_0005);
    // Recovery sequence
    apb(1'b1, CTRL_OFS, 32'h0000_0002);
    apb(1'b1, CTRL_OFS, 32'h0000_000A);
    apb(1'b1, CTRL_OFS, 32'h0000_001A);
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, DESC_OFS + 12'(4 * i), desc(DESC_ABORT, 4'(i + 2), 3'b000));
    end
    apb(1'b1, POST_OFS, 32'h0000_0004);
    wait_done();
    apb(1'b1, CTRL_OFS, 32'h0000_000A);
    apb(1'b1, CTRL_OFS, 32'h0000_0002);
    rd_chk(STATUS_OFS, 32'h0000_0007, 32'h0000_0002);
    // Embedded sync: first run is fine, a restart locks up
    apb(1'b1, CTRL_OFS, 32'h0000_0005);
    rd_chk(STATUS_OFS, 32'h0000_0004, 32'h0000_0000);
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    apb(1'b1, CTRL_OFS, 32'h0000_0005);
    rd_chk(STATUS_OFS, 32'h0000_0004, 32'h0000_0004);
    apb(1'b1, CTRL_OFS, 32'h0000_0008);
    apb(1'b1, CTRL_OFS, 32'h0000_0000);
    rd_chk(STATUS_OFS, 32'h0000_0004, 32'h0000_0000);
    // Direct-path capture works again after recovery
    apb(1'b1, DESC_OFS, desc(DESC_DATA, 4'h6, 3'b001));
    apb(1'b1, CTRL_OFS, 32'h0000_0003);
    apb(1'b1, POST_OFS, 32'h0000_0001);
    repeat (2) send_frame();
    chk(32'(wr_cnt[6]), 32'(FRAME_PIX));
    chk(32'(blank_wr), 32'h0000_0000);
    report_and_stop();
  end
endmodule // tb_top
`default_nettype wire
